/* logic/lcdcd_pkg.sv */
// Function
// R1: Pin reset low restores every setting; display memory is kept.
// R2: Host pulses the pin reset once logic supply is stable.
// R3: Display, scan, address and area settings take defaults at reset.
// R4: Power, oscillator, standby, bias, contrast, frame codes take defaults.
// R5: Gradients, signs, drive, temperatures clear; hysteresis 04h, 02h.
// R6: Select low marks opcodes, high marks data; don't-care bits ignored.
// R7: AEh/AFh display, A6h/A7h invert, A4h/A5h all pixels; bit 0 selects.
// R8: C4h parameter: bit 1 interlaced scan, bit 0 reversed common order.
// R9: 8Ah sets six-bit start line; B1h sets six-bit page address.
// R10: 13h takes column bit 8, then column bits 7 to 0.
// R11: 1Dh memory write, 1Ch memory read, E0h enters and EEh leaves RMW.
// R12: 84h/85h column or page increment; A0h/A1h forward or reversed columns.
// R13: 36h sets line-inversion count; E4h/E5h disable or enable inversion.
// R14: 6Dh takes three-bit duty code then six-bit start point.
// R15: AAh/ABh oscillator off/on; A8h/A9h normal or standby.
// R16: 5Fh takes codes B:A then D:C; 2Bh bit 0 sets frame-rate level.
// R17: 25h bits 6..0 enable power circuits; EAh bits 3..0 request discharge.
// R18: A2h sets four-bit bias; 81h takes contrast low byte then bits 9..8.
// R19: 4Eh takes eight gradient pairs; 39h takes sign flags low then high.
// R20: 68h/69h temperature detect; ECh three temperatures; EDh hysteresis.
// R21: E7h parameter 000x1001 sets drive method from bit 4; E3h does nothing.
// R22: FCh..FFh set test mode bits; host sends no unlisted opcodes there.
// R23: Each memory access advances column or page counter by one.
// R24: In RMW mode memory reads keep the counter; only writes advance it.
// R25: Host reads display memory only over the parallel path.
// R26: 8Eh two status bytes, EFh temperature byte, 8Fh identification byte.
// R27: A new opcode ends a partial command; latched parameters are kept.
package lcdcd_pkg;

  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_MODE = 8'h0C;

  localparam logic [7:0] OP_DISP = 8'hAE;
  localparam logic [7:0] OP_INV = 8'hA6;
  localparam logic [7:0] OP_ALLON = 8'hA4;
  localparam logic [7:0] OP_COMOUT = 8'hC4;
  localparam logic [7:0] OP_START = 8'h8A;
  localparam logic [7:0] OP_PAGE = 8'hB1;
  localparam logic [7:0] OP_COL = 8'h13;
  localparam logic [7:0] OP_MWRITE = 8'h1D;
  localparam logic [7:0] OP_MREAD = 8'h1C;
  localparam logic [7:0] OP_DIR = 8'h84;
  localparam logic [7:0] OP_COLDIR = 8'hA0;
  localparam logic [7:0] OP_NLINE = 8'h36;
  localparam logic [7:0] OP_NLON = 8'hE4;
  localparam logic [7:0] OP_AREA = 8'h6D;
  localparam logic [7:0] OP_RMW = 8'hE0;
  localparam logic [7:0] OP_RMWEND = 8'hEE;
  localparam logic [7:0] OP_OSC = 8'hAA;
  localparam logic [7:0] OP_FRAME = 8'h5F;
  localparam logic [7:0] OP_POWER = 8'h25;
  localparam logic [7:0] OP_LEVEL = 8'h2B;
  localparam logic [7:0] OP_BIAS = 8'hA2;
  localparam logic [7:0] OP_VOLUME = 8'h81;
  localparam logic [7:0] OP_DISCH = 8'hEA;
  localparam logic [7:0] OP_SAVE = 8'hA8;
  localparam logic [7:0] OP_GRAD = 8'h4E;
  localparam logic [7:0] OP_SIGN = 8'h39;
  localparam logic [7:0] OP_STATUS = 8'h8E;
  localparam logic [7:0] OP_TDET = 8'h68;
  localparam logic [7:0] OP_DRIVE = 8'hE7;
  localparam logic [7:0] OP_NOP = 8'hE3;
  localparam logic [7:0] OP_TRANGE = 8'hEC;
  localparam logic [7:0] OP_HYST = 8'hED;
  localparam logic [7:0] OP_TEMP = 8'hEF;
  localparam logic [7:0] OP_ID = 8'h8F;
  localparam logic [5:0] OP_TEST_HI = 6'h3F;

  localparam logic [7:0] DRIVE_MASK = 8'hEF;
  localparam logic [7:0] DRIVE_PATTERN = 8'h09;
  localparam int DRIVE_BIT = 4;
  localparam logic [3:0] IDX_MAX = 4'hF;

  typedef struct packed {
    logic display_on;
    logic pixel_invert_bit;
    logic all_pixels_on_bit;
    logic interlace_scan;
    logic common_reverse_bit;
    logic column_reverse_bit;
    logic page_direction;
    logic [5:0] start_line;
    logic [5:0] inversion_line_count;
    logic line_inversion_enable;
    logic [2:0] duty_code;
    logic [5:0] start_point_field;
    logic oscillator_enable;
    logic standby_bit;
    logic [3:0] frame_rate_code_a;
    logic [3:0] frame_rate_code_b;
    logic [3:0] frame_rate_code_c;
    logic [3:0] frame_rate_code_d;
    logic frame_rate_level_bit;
    logic [6:0] power_enable;
    logic [3:0] bias_code;
    logic [9:0] contrast_volume;
    logic [3:0] discharge;
    logic [63:0] gradient_code;
    logic [15:0] gradient_sign_flags;
    logic temp_detect_enable;
    logic drive_method_select;
    logic [6:0] switch_temp_first;
    logic [6:0] switch_temp_second;
    logic [6:0] switch_temp_third;
    logic [5:0] hysteresis_value;
    logic [3:0] frame_hysteresis_value;
    logic test_mode_enable;
    logic test_select;
  } lcdcd_cfg_t;

  localparam lcdcd_cfg_t CFG_RESET = '{
    duty_code: 3'h7,
    standby_bit: 1'h1,
    frame_rate_code_a: 4'h5,
    frame_rate_code_b: 4'h5,
    frame_rate_code_c: 4'h5,
    frame_rate_code_d: 4'h5,
    bias_code: 4'h9,
    hysteresis_value: 6'h04,
    frame_hysteresis_value: 4'h2,
    default: '0
  };

  typedef struct packed {
    logic we;
    logic [5:0] page;
    logic [8:0] col;
    logic [7:0] wdata;
  } lcdcd_mem_t;

endpackage

/* logic/lcdcd_top.sv */
// Implementation choices: the register addresses and register access over Wishbone.
module lcdcd_top #(
  parameter int NUM_COLS = 320,
  parameter int NUM_PAGES = 30,
  // Identification byte; the value is arbitrary.
  parameter logic [7:0] DEVICE_ID = 8'h5A
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Hardware reset pin
  input wire logic reset_n_pin,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Display memory port
  output lcdcd_pkg::lcdcd_mem_t mem,
  input wire logic [7:0] mem_rdata,
  // Temperature sensor code
  input wire logic [7:0] temp_code,
  // Latched settings
  output lcdcd_pkg::lcdcd_cfg_t cfg
);

  if (NUM_COLS < 1 || NUM_COLS > 512) begin : g_bad_cols
    $error("lcdcd_top: NUM_COLS out of range");
  end
  if (NUM_PAGES < 1 || NUM_PAGES > 64) begin : g_bad_pages
    $error("lcdcd_top: NUM_PAGES out of range");
  end

  localparam logic [8:0] COL_LAST = 9'(NUM_COLS - 1);
  localparam logic [5:0] PAGE_LAST = 6'(NUM_PAGES - 1);

  logic pin_s1_q;
  logic pin_s2_q;
  logic hw_clr;
  logic ack_q;
  logic [31:0] dat_q;
  logic req;
  logic wr_req;
  logic wr_cmd;
  logic wr_dat;
  logic rd_dat;
  logic [7:0] wbyte;
  logic [7:0] op_q;
  logic [3:0] idx_q;
  logic wr_mode_q;
  logic rd_mode_q;
  logic rmw_q;
  logic [5:0] page_set_q;
  logic [8:0] col_set_q;
  logic [5:0] page_q;
  logic [8:0] col_q;
  logic mem_we_q;
  logic [7:0] mem_wdata_q;
  logic mem_wr_ev;
  logic mem_rd_ev;
  logic param_ev;
  logic advance;
  lcdcd_pkg::lcdcd_cfg_t cfg_q;
  logic [7:0] rd_byte;
  logic [7:0] status0;
  logic [7:0] status1;

  function automatic logic pair(input logic [7:0] op,
                                input logic [7:0] base);
    pair = op[7:1] == base[7:1];
  endfunction

  function automatic logic has_params(input logic [7:0] op);
    unique case (op)
      lcdcd_pkg::OP_COMOUT, lcdcd_pkg::OP_START, lcdcd_pkg::OP_PAGE,
      lcdcd_pkg::OP_COL, lcdcd_pkg::OP_NLINE, lcdcd_pkg::OP_AREA,
      lcdcd_pkg::OP_FRAME, lcdcd_pkg::OP_POWER, lcdcd_pkg::OP_LEVEL,
      lcdcd_pkg::OP_BIAS, lcdcd_pkg::OP_VOLUME, lcdcd_pkg::OP_DISCH,
      lcdcd_pkg::OP_GRAD, lcdcd_pkg::OP_SIGN, lcdcd_pkg::OP_DRIVE,
      lcdcd_pkg::OP_TRANGE, lcdcd_pkg::OP_HYST: has_params = 1'b1;
      default: has_params = 1'b0;
    endcase
  endfunction

  function automatic logic is_readback(input logic [7:0] op);
    is_readback = op == lcdcd_pkg::OP_STATUS || op == lcdcd_pkg::OP_TEMP ||
                  op == lcdcd_pkg::OP_ID;
  endfunction

  // The pin is asynchronous to mclk, so it is synchronised before use.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= reset_n_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign hw_clr = ~pin_s2_q; // R1

  // One request per bus cycle; ack follows one clock after it is seen.
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wbyte = wb_dat_i[7:0];
  assign wr_req = req & wb_we_i & wb_sel_i[0];
  assign wr_cmd = wr_req & (wb_adr_i == lcdcd_pkg::REG_CMD);
  assign wr_dat = wr_req & (wb_adr_i == lcdcd_pkg::REG_DATA);
  assign rd_dat = req & ~wb_we_i & (wb_adr_i == lcdcd_pkg::REG_DATA);

  assign param_ev = wr_dat & has_params(op_q); // R6
  assign mem_wr_ev = wr_dat & ~has_params(op_q) & (wr_mode_q | rmw_q); // R11
  assign mem_rd_ev = rd_dat & ~is_readback(op_q) & (rd_mode_q | rmw_q); // R11
  assign advance = mem_wr_ev | (mem_rd_ev & ~rmw_q); // R24

  assign status0 = {cfg_q.display_on, cfg_q.oscillator_enable,
                    cfg_q.power_enable[5:0]};
  assign status1 = {1'b0, cfg_q.pixel_invert_bit, cfg_q.common_reverse_bit,
                    cfg_q.standby_bit, cfg_q.temp_detect_enable,
                    cfg_q.drive_method_select, 2'b00};

  always_comb begin
    rd_byte = 8'h00;
    if (op_q == lcdcd_pkg::OP_STATUS) begin
      rd_byte = (idx_q == 4'h0) ? status0 : status1; // R26
    end else if (op_q == lcdcd_pkg::OP_TEMP) begin
      rd_byte = temp_code; // R26
    end else if (op_q == lcdcd_pkg::OP_ID) begin
      rd_byte = DEVICE_ID; // R26
    end else if (mem_rd_ev) begin
      rd_byte = mem_rdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req && !wb_we_i) begin
        unique case (wb_adr_i)
          lcdcd_pkg::REG_CMD: dat_q <= {24'h000000, op_q};
          lcdcd_pkg::REG_DATA: dat_q <= {24'h000000, rd_byte};
          lcdcd_pkg::REG_ADDR: dat_q <= {1'b0, page_set_q, col_set_q,
                                         1'b0, page_q, col_q};
          lcdcd_pkg::REG_MODE: dat_q <= {17'h00000, rmw_q, wr_mode_q,
                                         rd_mode_q, idx_q, op_q};
          default: dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Command sequencing state.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      op_q <= lcdcd_pkg::OP_NOP;
      idx_q <= 4'h0;
      wr_mode_q <= 1'b0;
      rd_mode_q <= 1'b0;
      rmw_q <= 1'b0;
    end else if (hw_clr) begin
      op_q <= lcdcd_pkg::OP_NOP;
      idx_q <= 4'h0;
      wr_mode_q <= 1'b0;
      rd_mode_q <= 1'b0;
      rmw_q <= 1'b0;
    end else if (wr_cmd) begin
      op_q <= wbyte; // R27
      idx_q <= 4'h0; // R27
      wr_mode_q <= wbyte == lcdcd_pkg::OP_MWRITE; // R11
      rd_mode_q <= wbyte == lcdcd_pkg::OP_MREAD; // R11
      if (wbyte == lcdcd_pkg::OP_RMW) begin
        rmw_q <= 1'b1; // R11
      end else if (wbyte == lcdcd_pkg::OP_RMWEND) begin
        rmw_q <= 1'b0; // R11
      end
    end else if ((param_ev || (rd_dat && is_readback(op_q)))
                 && idx_q != lcdcd_pkg::IDX_MAX) begin
      idx_q <= idx_q + 4'h1;
    end
  end

  // Address settings and the running address counters.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      page_set_q <= 6'h00;
      col_set_q <= 9'h000;
      page_q <= 6'h00;
      col_q <= 9'h000;
    end else if (hw_clr) begin
      page_set_q <= 6'h00; // R3
      col_set_q <= 9'h000; // R3
      page_q <= 6'h00;
      col_q <= 9'h000;
    end else if (wr_cmd && (wbyte == lcdcd_pkg::OP_MWRITE ||
                            wbyte == lcdcd_pkg::OP_MREAD)) begin
      page_q <= page_set_q;
      col_q <= col_set_q;
    end else if (param_ev && op_q == lcdcd_pkg::OP_PAGE && idx_q == 4'h0) begin
      page_set_q <= wbyte[5:0]; // R9
      page_q <= wbyte[5:0];
    end else if (param_ev && op_q == lcdcd_pkg::OP_COL && idx_q == 4'h0) begin
      col_set_q[8] <= wbyte[0]; // R10
      col_q[8] <= wbyte[0];
    end else if (param_ev && op_q == lcdcd_pkg::OP_COL && idx_q == 4'h1) begin
      col_set_q[7:0] <= wbyte; // R10
      col_q[7:0] <= wbyte;
    end else if (advance) begin
      if (cfg_q.page_direction) begin
        page_q <= (page_q >= PAGE_LAST) ? 6'h00 : page_q + 6'h01; // R23
      end else begin
        col_q <= (col_q >= COL_LAST) ? 9'h000 : col_q + 9'h001; // R23
      end
    end
  end

  // Memory write strobe and its data; the address comes from the counters.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_we_q <= 1'b0;
      mem_wdata_q <= 8'h00;
    end else begin
      mem_we_q <= mem_wr_ev & ~hw_clr;
      if (mem_wr_ev) begin
        mem_wdata_q <= wbyte;
      end
    end
  end

  // Reads need the address now, so the counters drive it directly.
  assign mem = '{we: mem_we_q, page: page_q, col: col_q, wdata: mem_wdata_q};

  // Configuration store.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q <= lcdcd_pkg::CFG_RESET;
    end else if (hw_clr) begin
      cfg_q <= lcdcd_pkg::CFG_RESET; // R1 R3 R4 R5
    end else if (wr_cmd) begin
      if (pair(wbyte, lcdcd_pkg::OP_DISP)) begin
        cfg_q.display_on <= wbyte[0]; // R7
      end
      if (pair(wbyte, lcdcd_pkg::OP_INV)) begin
        cfg_q.pixel_invert_bit <= wbyte[0]; // R7
      end
      if (pair(wbyte, lcdcd_pkg::OP_ALLON)) begin
        cfg_q.all_pixels_on_bit <= wbyte[0]; // R7
      end
      if (pair(wbyte, lcdcd_pkg::OP_DIR)) begin
        cfg_q.page_direction <= wbyte[0]; // R12
      end
      if (pair(wbyte, lcdcd_pkg::OP_COLDIR)) begin
        cfg_q.column_reverse_bit <= wbyte[0]; // R12
      end
      if (pair(wbyte, lcdcd_pkg::OP_NLON)) begin
        cfg_q.line_inversion_enable <= wbyte[0]; // R13
      end
      if (pair(wbyte, lcdcd_pkg::OP_OSC)) begin
        cfg_q.oscillator_enable <= wbyte[0]; // R15
      end
      if (pair(wbyte, lcdcd_pkg::OP_SAVE)) begin
        cfg_q.standby_bit <= wbyte[0]; // R15
      end
      if (pair(wbyte, lcdcd_pkg::OP_TDET)) begin
        cfg_q.temp_detect_enable <= wbyte[0]; // R20
      end
      if (wbyte[7:2] == lcdcd_pkg::OP_TEST_HI) begin
        cfg_q.test_mode_enable <= wbyte[1]; // R22
        cfg_q.test_select <= wbyte[0]; // R22
      end
    end else if (param_ev) begin
      unique case (op_q)
        lcdcd_pkg::OP_COMOUT: begin
          if (idx_q == 4'h0) begin
            cfg_q.interlace_scan <= wbyte[1]; // R8
            cfg_q.common_reverse_bit <= wbyte[0]; // R8
          end
        end
        lcdcd_pkg::OP_START: begin
          if (idx_q == 4'h0) begin
            cfg_q.start_line <= wbyte[5:0]; // R9
          end
        end
        lcdcd_pkg::OP_NLINE: begin
          if (idx_q == 4'h0) begin
            cfg_q.inversion_line_count <= wbyte[5:0]; // R13
          end
        end
        lcdcd_pkg::OP_AREA: begin
          if (idx_q == 4'h0) begin
            cfg_q.duty_code <= wbyte[2:0]; // R14
          end else if (idx_q == 4'h1) begin
            cfg_q.start_point_field <= wbyte[5:0]; // R14
          end
        end
        lcdcd_pkg::OP_FRAME: begin
          if (idx_q == 4'h0) begin
            cfg_q.frame_rate_code_b <= wbyte[7:4]; // R16
            cfg_q.frame_rate_code_a <= wbyte[3:0]; // R16
          end else if (idx_q == 4'h1) begin
            cfg_q.frame_rate_code_d <= wbyte[7:4]; // R16
            cfg_q.frame_rate_code_c <= wbyte[3:0]; // R16
          end
        end
        lcdcd_pkg::OP_LEVEL: begin
          if (idx_q == 4'h0) begin
            cfg_q.frame_rate_level_bit <= wbyte[0]; // R16
          end
        end
        lcdcd_pkg::OP_POWER: begin
          if (idx_q == 4'h0) begin
            cfg_q.power_enable <= wbyte[6:0]; // R17
          end
        end
        lcdcd_pkg::OP_DISCH: begin
          if (idx_q == 4'h0) begin
            cfg_q.discharge <= wbyte[3:0]; // R17
          end
        end
        lcdcd_pkg::OP_BIAS: begin
          if (idx_q == 4'h0) begin
            cfg_q.bias_code <= wbyte[3:0]; // R18
          end
        end
        lcdcd_pkg::OP_VOLUME: begin
          if (idx_q == 4'h0) begin
            cfg_q.contrast_volume[7:0] <= wbyte; // R18
          end else if (idx_q == 4'h1) begin
            cfg_q.contrast_volume[9:8] <= wbyte[1:0]; // R18
          end
        end
        lcdcd_pkg::OP_GRAD: begin
          if (idx_q < 4'h8) begin
            cfg_q.gradient_code[idx_q[2:0] * 8 +: 8] <= wbyte; // R19
          end
        end
        lcdcd_pkg::OP_SIGN: begin
          if (idx_q == 4'h0) begin
            cfg_q.gradient_sign_flags[7:0] <= wbyte; // R19
          end else if (idx_q == 4'h1) begin
            cfg_q.gradient_sign_flags[15:8] <= wbyte; // R19
          end
        end
        lcdcd_pkg::OP_DRIVE: begin
          if (idx_q == 4'h0 && (wbyte & lcdcd_pkg::DRIVE_MASK)
              == lcdcd_pkg::DRIVE_PATTERN) begin
            cfg_q.drive_method_select <= wbyte[lcdcd_pkg::DRIVE_BIT]; // R21
          end
        end
        lcdcd_pkg::OP_TRANGE: begin
          if (idx_q == 4'h0) begin
            cfg_q.switch_temp_first <= wbyte[6:0]; // R20
          end else if (idx_q == 4'h1) begin
            cfg_q.switch_temp_second <= wbyte[6:0]; // R20
          end else if (idx_q == 4'h2) begin
            cfg_q.switch_temp_third <= wbyte[6:0]; // R20
          end
        end
        lcdcd_pkg::OP_HYST: begin
          if (idx_q == 4'h0) begin
            cfg_q.hysteresis_value <= wbyte[5:0]; // R20
          end else if (idx_q == 4'h1) begin
            cfg_q.frame_hysteresis_value <= wbyte[3:0]; // R20
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign cfg = cfg_q;

endmodule

/* dv/lcdcd_mem_model.sv */
module lcdcd_mem_model (
  // Clock
  input wire logic mclk,
  // Memory port of the block
  input wire lcdcd_pkg::lcdcd_mem_t mem,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] store [64][512];
  logic [5:0] page_q;
  logic [8:0] col_q;
  initial begin
    for (int p = 0; p < 64; p++) begin
      for (int c = 0; c < 512; c++) begin
        store[p][c] = c[7:0] ^ 8'h3C;
      end
    end
  end
  assign mem_rdata = store[mem.page][mem.col];
  // The write pulse comes after the counter has moved on, so it lands on
  // the address seen one cycle earlier.
  always @(posedge mclk) begin
    page_q <= mem.page;
    col_q <= mem.col;
    if (mem.we) begin
      store[page_q][col_q] <= mem.wdata;
    end
  end
endmodule

/* dv/lcdcd_chk.sv */
module lcdcd_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_n_pin,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Memory and settings
  input wire lcdcd_pkg::lcdcd_mem_t mem,
  input wire lcdcd_pkg::lcdcd_cfg_t cfg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_has_req: assert property (
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_we_from_data: assert property ($rose(mem.we) |-> $past(
    wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == lcdcd_pkg::REG_DATA))
    else $error("memory write without data write");
  a_wdata_from_bus: assert property (
    mem.we |-> mem.wdata == $past(wb_dat_i[7:0]))
    else $error("memory write data differs from bus byte");
  a_we_with_ack: assert property (mem.we |-> wb_ack_o)
    else $error("memory write outside acknowledged access");
  a_pin_defaults: assert property (
    !reset_n_pin [*3] |=> cfg == lcdcd_pkg::CFG_RESET)
    else $error("settings not at defaults under pin reset");
  a_pin_no_write: assert property (!reset_n_pin [*3] |=> !mem.we)
    else $error("memory written under pin reset");
  a_addr_stable: assert property (
    !(wb_cyc_i && wb_stb_i) && reset_n_pin && $past(reset_n_pin)
    |=> $stable({mem.page, mem.col}))
    else $error("address counter moved without access");
  c_mem_write: cover property (mem.we);
  c_pin_reset: cover property (!reset_n_pin [*3]);
  c_ack: cover property ($rose(wb_ack_o) && !wb_we_i);
endmodule

bind lcdcd_top lcdcd_chk u_chk (.mclk, .rst, .reset_n_pin, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .mem, .cfg);

/* dv/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Identification byte; the value is arbitrary.
  localparam logic [7:0] ID_VAL = 8'hC6;
  logic mclk, rst, reset_n_pin, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, mem_rdata, temp_code;
  logic [3:0] wb_sel_i, wr_sel;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  lcdcd_pkg::lcdcd_mem_t mem;
  lcdcd_pkg::lcdcd_cfg_t cfg;
  int failures, samples_checked;

  lcdcd_top #(.DEVICE_ID(ID_VAL)) u_dut (.mclk, .rst, .reset_n_pin,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .mem, .mem_rdata, .temp_code, .cfg);
  lcdcd_mem_model u_mem (.mclk, .mem, .mem_rdata);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, d);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= wr_sel;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      failures++;
      $display("MISMATCH wb_ack_o expected 1 seen %b", wb_ack_o);
      complete_run();
    end
  endtask

  task automatic op(input logic [7:0] x);
    wb(1'b1, lcdcd_pkg::REG_CMD, x);
  endtask

  task automatic prm(input logic [7:0] x);
    wb(1'b1, lcdcd_pkg::REG_DATA, x);
  endtask

  task automatic rdd;
    wb(1'b0, lcdcd_pkg::REG_DATA, 8'h00);
  endtask

  task automatic cfg_dflt;
    samples_checked++;
    if (cfg !== lcdcd_pkg::CFG_RESET) begin
      failures++;
      $display("MISMATCH cfg expected %h seen %h", lcdcd_pkg::CFG_RESET, cfg);
    end
    chk("address", 15'h0, {mem.page, mem.col});
  endtask

  function automatic logic fld(input logic [7:0] o);
    case (o)
      8'hAE: return cfg.display_on;
      8'hA6: return cfg.pixel_invert_bit;
      8'hA4: return cfg.all_pixels_on_bit;
      8'hA8: return cfg.standby_bit;
      8'h84: return cfg.page_direction;
      8'hA0: return cfg.column_reverse_bit;
      8'hE4: return cfg.line_inversion_enable;
      8'h68: return cfg.temp_detect_enable;
      default: return cfg.oscillator_enable;
    endcase
  endfunction

  task automatic t_toggles;
    logic [7:0] ops [9];
    ops = '{8'hAE, 8'hA6, 8'hA4, 8'hAA, 8'hA8, 8'h84, 8'hA0, 8'hE4, 8'h68};
    foreach (ops[i]) begin
      op(ops[i] | 8'h01);
      chk("flag_on", 1, fld(ops[i]));
      op(ops[i]);
      chk("flag_off", 0, fld(ops[i]));
    end
    for (int k = 0; k < 4; k++) begin
      op(8'hFC | 8'(k));
      chk("test", k, {cfg.test_mode_enable, cfg.test_select});
    end
    op(8'hFC);
    $display("Test toggles done");
  endtask

  task automatic t_params;
    op(8'hC4);
    prm(8'hFE);
    chk("scan", 2'b10, {cfg.interlace_scan, cfg.common_reverse_bit});
    op(8'h8A);
    prm(8'hFF);
    chk("start", 6'h3F, cfg.start_line);
    op(8'h6D);
    prm(8'hFA);
    op(8'hE3);
    chk("area", 9'h080, {cfg.duty_code, cfg.start_point_field});
    op(8'h81);
    prm(8'h34);
    prm(8'h03);
    op(8'hA2);
    prm(8'hF3);
    chk("volume", 14'h3343, {cfg.contrast_volume, cfg.bias_code});
    op(8'h5F);
    prm(8'h21);
    prm(8'h43);
    op(8'h2B);
    prm(8'hFF);
    chk("frame", 17'h08643, {cfg.frame_rate_code_d, cfg.frame_rate_code_c,
      cfg.frame_rate_code_b, cfg.frame_rate_code_a,
      cfg.frame_rate_level_bit});
    op(8'h25);
    prm(8'hFF);
    op(8'hEA);
    prm(8'hF5);
    chk("power", 11'h7F5, {cfg.power_enable, cfg.discharge});
    op(8'h4E);
    for (int i = 0; i < 8; i++) begin
      prm({4'(2 * i + 1), 4'(2 * i)});
    end
    op(8'h39);
    prm(8'h34);
    prm(8'h12);
    chk("grad", 64'hFEDCBA9876543210, cfg.gradient_code);
    chk("sign", 16'h1234, cfg.gradient_sign_flags);
    op(8'hEC);
    prm(8'h81);
    prm(8'h02);
    prm(8'h7F);
    op(8'hED);
    prm(8'hFF);
    prm(8'hFA);
    chk("temps", 31'h105FFFA, {cfg.switch_temp_first, cfg.switch_temp_second,
      cfg.switch_temp_third, cfg.hysteresis_value,
      cfg.frame_hysteresis_value});
    op(8'hE7);
    prm(8'h19);
    op(8'hE7);
    prm(8'h18);
    op(8'h36);
    prm(8'hEC);
    chk("drive", 7'h6C, {cfg.drive_method_select,
      cfg.inversion_line_count});
    $display("Test parameters done");
  endtask

  task automatic t_memory;
    op(8'h13);
    prm(8'h00);
    prm(8'h05);
    chk("col_set", 9'h005, mem.col);
    op(8'h1D);
    prm(8'hAA);
    prm(8'h55);
    chk("col_adv", 9'h007, mem.col);
    op(8'h1C);
    rdd();
    chk("rd0", 8'hAA, rd);
    rdd();
    chk("rd1", 8'h55, rd);
    op(8'hE0);
    rdd();
    rdd();
    chk("rmw_rd", {8'h07 ^ 8'h3C, 9'h007}, {rd, mem.col});
    prm(8'hC3);
    chk("rmw_wr", 9'h008, mem.col);
    op(8'hEE);
    op(8'h85);
    op(8'h1D);
    prm(8'h11);
    chk("page_adv", {6'h01, 9'h005}, {mem.page, mem.col});
    op(8'hB1);
    prm(8'hDD);
    chk("page_set", 6'h1D, mem.page);
    $display("Test memory done");
  endtask

  task automatic t_readback;
    wb(1'b0, lcdcd_pkg::REG_ADDR, 8'h00);
    chk("addr_reg", 32'h3A053A05, rd);
    op(8'h8E);
    rdd();
    chk("status0", 8'h3F, rd);
    rdd();
    chk("status1", 8'h04, rd);
    op(8'hEF);
    rdd();
    chk("temp", 8'h9C, rd);
    op(8'h8F);
    rdd();
    chk("id", ID_VAL, rd);
    wb(1'b0, 8'h40, 8'h00);
    chk("unmapped", 8'h00, rd);
    wr_sel = 4'h0;
    op(8'hAF);
    wr_sel = 4'h1;
    chk("sel_off", 1'b0, cfg.display_on);
    $display("Test read-back done");
  endtask

  task automatic t_pin_reset;
    op(8'hAF);
    reset_n_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    op(8'hAF);
    reset_n_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    cfg_dflt();
    chk("mem_kept", 8'h11, u_mem.store[0][5]);
    $display("Test pin reset done");
  endtask

  initial begin
    rst = 1'b1;
    reset_n_pin = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h1;
    wr_sel = 4'h1;
    wb_dat_i = 32'h0;
    temp_code = 8'h9C;
    failures = 0;
    samples_checked = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    reset_n_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    cfg_dflt();
    t_toggles();
    t_params();
    t_memory();
    t_readback();
    t_pin_reset();
    complete_run();
  end
endmodule
